// [rtl/dsp_row_interface_control.v]
// Purpose: Row interface and control distribution for a hard multiply-add block
// Assumes: All pin inputs are asynchronous to clk_i; APB master on clk_i
// Notes: Bank clocks are sampled lines; a bank loads on a rising edge of its line
//
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/100ps
`include "dsp_row_consts.vh"

module dsp_row_interface_control #(
  parameter ROWS = 8,
  parameter ROW_W = 18,
  parameter LINK_W = 10,
  parameter ACC_W = 24
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // APB slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  // Bank clocks enter rows 3 to 6, enables on the same rows
  input wire [3:0] bank_clock_i,
  input wire [3:0] bank_enable_i,
  // Clears enter rows 1, 4, 5 and 7
  input wire [3:0] bank_clear_i,
  // Sign controls enter rows 1 and 6
  input wire sign_a_i,
  input wire sign_b_i,
  // Add selects enter rows 3 and 7
  input wire upper_pair_add_sel_i,
  input wire lower_pair_add_sel_i,
  // Accumulator zero controls enter rows 2 and 7
  input wire upper_accumulator_zero_i,
  input wire lower_accumulator_zero_i,
  // Direct connections from neighbour logic clusters, ten per row each
  input wire [ROWS*LINK_W-1:0] from_left_i,
  input wire [ROWS*LINK_W-1:0] from_right_i,
  // Per-row operands and distributed controls into the arithmetic rows
  output reg [ROWS*ROW_W-1:0] operand_o,
  output reg [`SLOT_COUNT-1:0] row_ctl_o,
  output reg product_signed_o,
  output reg [1:0] overflow_o,
  // Row outputs to neighbours and to row or column routing
  output wire [ROWS*9-1:0] to_left_o,
  output wire [ROWS*9-1:0] to_right_o,
  output reg [ROWS*ROW_W-1:0] route_o
);

  localparam DAT_W = 2 * ROWS * LINK_W;

  // Software state
  reg [8:0] ctrl;
  reg [29:0] slot_cfg;
  reg [19:0] bank_cfg;

  // Synchronisers
  reg [`CTL_COUNT-1:0] ctl_meta;
  reg [`CTL_COUNT-1:0] ctl_sync;
  reg [DAT_W-1:0] dat_meta;
  reg [DAT_W-1:0] dat_sync;
  reg [3:0] clock_prev;

  wire [`CTL_COUNT-1:0] ctl_pins;
  wire [3:0] tick;
  wire [3:0] clear;
  wire [`SLOT_COUNT-1:0] ctl_q;
  wire [ROWS*ROW_W-1:0] in_q;
  wire [ROWS*ROW_W-1:0] pipe_q;
  wire [ROWS*ROW_W-1:0] out_q;
  wire split;
  wire [1:0] out_clk_sel;
  wire [1:0] out_clr_sel;
  wire acc_tick;
  wire acc_clear;
  wire any_signed;
  wire [ACC_W-1:0] acc_upper;
  wire [ACC_W-1:0] acc_lower;

  // Eighteen control lines gathered into one vector
  assign ctl_pins = {lower_accumulator_zero_i, upper_accumulator_zero_i,
                     lower_pair_add_sel_i, upper_pair_add_sel_i,
                     sign_b_i, sign_a_i,
                     bank_enable_i, bank_clear_i, bank_clock_i};

  // Two-flop synchronisers for every pin input
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctl_meta <= {`CTL_COUNT{1'b0}};
      ctl_sync <= {`CTL_COUNT{1'b0}};
      dat_meta <= {DAT_W{1'b0}};
      dat_sync <= {DAT_W{1'b0}};
      clock_prev <= 4'h0;
    end else begin
      ctl_meta <= ctl_pins;
      ctl_sync <= ctl_meta;
      dat_meta <= {from_right_i, from_left_i};
      dat_sync <= dat_meta;
      clock_prev <= ctl_sync[`CTL_CLOCK_LSB +: 4];
    end
  end

  // A bank clock ticks on a rising edge of its line while its own enable is high
  assign tick = ctl_sync[`CTL_CLOCK_LSB +: 4] & ~clock_prev
                & ctl_sync[`CTL_ENABLE_LSB +: 4];
  assign clear = ctl_sync[`CTL_CLEAR_LSB +: 4];
  assign split = ctrl[`CTRL_SPLIT];

  // Six registerable controls, each with its own clock and clear choice
  genvar s;
  generate
    for (s = 0; s < `SLOT_COUNT; s = s + 1) begin : g_slot
      bank_reg #(
        .WIDTH(1)
      ) u_slot (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cfg_i(slot_cfg[s*`CFG_W +: `CFG_W]),
        .tick_i(tick),
        .clear_i(clear),
        .d_i(ctl_sync[`CTL_SLOT_LSB + s]),
        .q_o(ctl_q[s])
      );
    end
  endgenerate

  // Per-row data path through input, pipeline and output banks
  genvar r;
  generate
    for (r = 0; r < ROWS; r = r + 1) begin : g_row
      wire [LINK_W-1:0] left_lines;
      wire [LINK_W-1:0] right_lines;
      wire [LINK_W-1:0] fb_lines;
      wire [ROW_W-1:0] row_data;
      wire [4:0] lower_cfg;

      // Thirty local lines: ten left, ten right, ten fed back from this row
      assign left_lines = dat_sync[r*LINK_W +: LINK_W];
      assign right_lines = dat_sync[(ROWS+r)*LINK_W +: LINK_W];
      assign fb_lines = route_o[r*ROW_W +: LINK_W];

      // Eighteen operand bits picked from the local lines
      assign row_data = ctrl[`CTRL_SRC_LSB + r] ?
                        {fb_lines[8:0], left_lines[8:0]} :
                        {right_lines[8:0], left_lines[8:0]};

      // In split mode the low half takes its own bank control
      assign lower_cfg = split ? bank_cfg[`BANK_IN_LOWER +: `CFG_W] :
                         bank_cfg[`BANK_IN_UPPER +: `CFG_W];

      // Input banks of nine bits each
      bank_reg #(
        .WIDTH(9)
      ) u_in_lo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cfg_i(lower_cfg),
        .tick_i(tick),
        .clear_i(clear),
        .d_i(row_data[8:0]),
        .q_o(in_q[r*ROW_W +: 9])
      );

      bank_reg #(
        .WIDTH(9)
      ) u_in_hi (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cfg_i(bank_cfg[`BANK_IN_UPPER +: `CFG_W]),
        .tick_i(tick),
        .clear_i(clear),
        .d_i(row_data[17:9]),
        .q_o(in_q[r*ROW_W+9 +: 9])
      );

      // Pipeline bank of eighteen bits
      bank_reg #(
        .WIDTH(ROW_W)
      ) u_pipe (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cfg_i(bank_cfg[`BANK_PIPE +: `CFG_W]),
        .tick_i(tick),
        .clear_i(clear),
        .d_i(in_q[r*ROW_W +: ROW_W]),
        .q_o(pipe_q[r*ROW_W +: ROW_W])
      );

      // Output bank of eighteen bits
      bank_reg #(
        .WIDTH(ROW_W)
      ) u_out (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cfg_i(bank_cfg[`BANK_OUT +: `CFG_W]),
        .tick_i(tick),
        .clear_i(clear),
        .d_i(pipe_q[r*ROW_W +: ROW_W]),
        .q_o(out_q[r*ROW_W +: ROW_W])
      );

      // Nine outputs to each neighbour, taken from the route flops
      assign to_left_o[r*9 +: 9] = route_o[r*ROW_W +: 9];
      assign to_right_o[r*9 +: 9] = route_o[r*ROW_W+9 +: 9];
    end
  endgenerate

  // Accumulators follow the output bank clock and clear
  assign out_clk_sel = bank_cfg[`BANK_OUT+`CFG_CLK_LSB +: 2];
  assign out_clr_sel = bank_cfg[`BANK_OUT+`CFG_CLR_LSB +: 2];
  assign acc_tick = tick[out_clk_sel];
  assign acc_clear = clear[out_clr_sel];
  assign any_signed = ctl_q[`SLOT_SIGN_A] | ctl_q[`SLOT_SIGN_B];

  // Two accumulating adder pairs: rows 0 and 1 upper, rows 4 and 5 lower
  genvar p;
  generate
    for (p = 0; p < 2; p = p + 1) begin : g_pair
      reg [ACC_W-1:0] acc;
      wire [ROW_W-1:0] op_a;
      wire [ROW_W-1:0] op_b;
      wire [ACC_W:0] ext_a;
      wire [ACC_W:0] ext_b;
      wire [ACC_W:0] term;
      wire [ACC_W:0] feedback;
      wire [ACC_W:0] sum;
      wire add_sel;
      wire zero_sel;
      wire over;

      assign op_a = pipe_q[(4*p)*ROW_W +: ROW_W];
      assign op_b = pipe_q[(4*p+1)*ROW_W +: ROW_W];
      assign add_sel = ctl_q[`SLOT_UPPER_ADD + p];
      assign zero_sel = ctl_q[`SLOT_UPPER_ZERO + p];

      // Sign high extends the operand as a signed number
      assign ext_a = {{(ACC_W+1-ROW_W){op_a[ROW_W-1] & ctl_q[`SLOT_SIGN_A]}}, op_a};
      assign ext_b = {{(ACC_W+1-ROW_W){op_b[ROW_W-1] & ctl_q[`SLOT_SIGN_B]}}, op_b};

      // High adds, low subtracts
      assign term = add_sel ? ext_a + ext_b : ext_a - ext_b;

      // Zero control drops the feedback so a new run starts this cycle
      assign feedback = zero_sel ? {(ACC_W+1){1'b0}} :
                        {acc[ACC_W-1] & any_signed, acc};
      assign sum = feedback + term;

      // Signed overflow on sign disagreement, unsigned when out of range
      assign over = any_signed ? (sum[ACC_W] ^ sum[ACC_W-1]) : sum[ACC_W];

      always @(posedge clk_i) begin
        if (rst_i) begin
          acc <= {ACC_W{1'b0}};
          overflow_o[p] <= 1'b0;
        end else if (acc_clear) begin
          acc <= {ACC_W{1'b0}};
          overflow_o[p] <= 1'b0;
        end else begin
          overflow_o[p] <= acc_tick & over;
          if (acc_tick) begin
            acc <= sum[ACC_W-1:0];
          end
        end
      end
    end
  endgenerate

  assign acc_upper = g_pair[0].acc;
  assign acc_lower = g_pair[1].acc;

  // Registered row outputs: 18 operand bits per row plus distributed controls
  always @(posedge clk_i) begin
    if (rst_i) begin
      operand_o <= {(ROWS*ROW_W){1'b0}};
      route_o <= {(ROWS*ROW_W){1'b0}};
      row_ctl_o <= {`SLOT_COUNT{1'b0}};
      product_signed_o <= 1'b0;
    end else begin
      operand_o <= pipe_q;
      route_o <= out_q;
      row_ctl_o <= ctl_q;
      product_signed_o <= any_signed;
    end
  end

  // APB slave: answers one cycle into the access phase
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= `CTRL_RST;
      slot_cfg <= `SLOT_CFG_RST;
      bank_cfg <= `BANK_CFG_RST;
      prdata_o <= 32'h00000000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h00000000;
      if (psel_i && penable_i && !pready_o) begin
        pready_o <= 1'b1;
        case (paddr_i)
          `OFS_CTRL: begin
            prdata_o <= {23'h000000, ctrl};
            if (pwrite_i) begin
              ctrl <= pwdata_i[8:0];
            end
          end
          `OFS_SLOT_CFG: begin
            prdata_o <= {2'h0, slot_cfg};
            if (pwrite_i) begin
              slot_cfg <= pwdata_i[29:0];
            end
          end
          `OFS_BANK_CFG: begin
            prdata_o <= {12'h000, bank_cfg};
            if (pwrite_i) begin
              bank_cfg <= pwdata_i[19:0];
            end
          end
          `OFS_STATUS: begin
            prdata_o <= {6'h00, overflow_o, row_ctl_o, ctl_sync};
          end
          `OFS_ACC_UPPER: begin
            prdata_o <= {{(32-ACC_W){1'b0}}, acc_upper};
          end
          `OFS_ACC_LOWER: begin
            prdata_o <= {{(32-ACC_W){1'b0}}, acc_lower};
          end
          default: begin
            pslverr_o <= 1'b1;
          end
        endcase
      end
    end
  end

endmodule // dsp_row_interface_control

// [rtl/dsp_row_consts.vh]
// Purpose: Constants for the multiply-add row interface and control distribution
// Assumes: APB register offsets are byte addresses on a 32-bit data bus
// Notes: Configuration fields share one 5-bit layout: enable, clock select, clear select
`ifndef DSP_ROW_CONSTS_VH
`define DSP_ROW_CONSTS_VH

// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_SLOT_CFG 8'h04
`define OFS_BANK_CFG 8'h08
`define OFS_STATUS 8'h0c
`define OFS_ACC_UPPER 8'h10
`define OFS_ACC_LOWER 8'h14

// Reset values
`define CTRL_RST 9'h000
`define SLOT_CFG_RST 30'h00000000
`define BANK_CFG_RST 20'h00000

// Control register fields
`define CTRL_SPLIT 0
`define CTRL_SRC_LSB 1

// Common 5-bit configuration field layout
`define CFG_W 5
`define CFG_REG 0
`define CFG_CLK_LSB 1
`define CFG_CLR_LSB 3

// Bank configuration field positions
`define BANK_IN_UPPER 0
`define BANK_IN_LOWER 5
`define BANK_PIPE 10
`define BANK_OUT 15

// Control pin vector layout, eighteen lines in all
`define CTL_COUNT 18
`define CTL_CLOCK_LSB 0
`define CTL_CLEAR_LSB 4
`define CTL_ENABLE_LSB 8
`define CTL_SLOT_LSB 12
`define SLOT_COUNT 6

// Slot order within the registerable controls
`define SLOT_SIGN_A 0
`define SLOT_SIGN_B 1
`define SLOT_UPPER_ADD 2
`define SLOT_LOWER_ADD 3
`define SLOT_UPPER_ZERO 4
`define SLOT_LOWER_ZERO 5

// Entry row of each control line, numbered 0 to 7
`define ROW_SIGN_A 1
`define ROW_SIGN_B 6
`define ROW_UPPER_ADD 3
`define ROW_LOWER_ADD 7
`define ROW_UPPER_ZERO 2
`define ROW_LOWER_ZERO 7

`endif

// [rtl/bank_reg.v]
// Purpose: One register bank with selectable clock line and clear line
// Assumes: Clock ticks and clear levels are already synchronised to clk_i
// Notes: With the enable bit low the bank is bypassed and q follows d
`timescale 1ns/100ps
`include "dsp_row_consts.vh"

module bank_reg #(
  parameter WIDTH = 18
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Bank configuration
  input wire [4:0] cfg_i,
  // Shared clock ticks and clear levels
  input wire [3:0] tick_i,
  input wire [3:0] clear_i,
  // Data
  input wire [WIDTH-1:0] d_i,
  output wire [WIDTH-1:0] q_o
);

  reg [WIDTH-1:0] store;
  wire [1:0] clk_sel;
  wire [1:0] clr_sel;

  // Field split of the configuration
  assign clk_sel = cfg_i[`CFG_CLK_LSB +: 2];
  assign clr_sel = cfg_i[`CFG_CLR_LSB +: 2];

  // Clear has priority over the selected clock tick
  always @(posedge clk_i) begin
    if (rst_i) begin
      store <= {WIDTH{1'b0}};
    end else if (clear_i[clr_sel]) begin
      store <= {WIDTH{1'b0}};
    end else if (tick_i[clk_sel]) begin
      store <= d_i;
    end
  end

  // Registered or bypassed output
  assign q_o = cfg_i[`CFG_REG] ? store : d_i;

endmodule // bank_reg

// [testbench/dsp_row_checks_asserts.sv]
// Purpose: Port checks for the row interface block
// Assumes: One clock, synchronous active-high reset
// Notes: Bound into every instance of the block
`timescale 1ns/100ps
`include "dsp_row_consts.vh"
module dsp_row_checks #(
  parameter ROWS = 8,
  parameter ROW_W = 18
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // APB
  input wire psel_i,
  input wire penable_i,
  input wire [7:0] paddr_i,
  input wire [31:0] prdata_o,
  input wire pready_o,
  input wire pslverr_o,
  // Row side
  input wire [`SLOT_COUNT-1:0] row_ctl_o,
  input wire product_signed_o,
  input wire [1:0] overflow_o,
  input wire [ROWS*9-1:0] to_left_o,
  input wire [ROWS*9-1:0] to_right_o,
  input wire [ROWS*ROW_W-1:0] route_o
);
  wire [ROWS*9-1:0] left_exp;
  wire [ROWS*9-1:0] right_exp;
  genvar r;
  // Neighbour outputs expected from each routed row
  generate
    for (r = 0; r < ROWS; r = r + 1) begin : g_row
      assign left_exp[r*9+:9] = route_o[r*ROW_W+:9];
      assign right_exp[r*9+:9] = route_o[r*ROW_W+9+:9];
    end
  endgenerate
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // First cycle of an access phase
  sequence s_take;
    psel_i && penable_i && !pready_o;
  endsequence
  a_ready_timing: assert property (s_take |=> pready_o)
    else $error("pready late");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("pready held");
  a_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0)
    else $error("read data outside answer");
  a_err_decode: assert property (s_take |=> pslverr_o == !$past(paddr_i inside {`OFS_CTRL,
    `OFS_SLOT_CFG, `OFS_BANK_CFG, `OFS_STATUS, `OFS_ACC_UPPER, `OFS_ACC_LOWER}))
    else $error("error flag wrong");
  a_err_quiet: assert property (pslverr_o |-> pready_o && prdata_o == 32'h0)
    else $error("error answer malformed");
  a_signed_or: assert property (product_signed_o == (row_ctl_o[0] | row_ctl_o[1]))
    else $error("product sign wrong");
  a_left_map: assert property (to_left_o == left_exp)
    else $error("left outputs wrong");
  a_right_map: assert property (to_right_o == right_exp)
    else $error("right outputs wrong");
  a_ovf_pulse: assert property (overflow_o != 2'b00 |=> (overflow_o & $past(overflow_o)) == 2'b00)
    else $error("overflow held");
endmodule // dsp_row_checks

bind dsp_row_interface_control dsp_row_checks #(.ROWS(ROWS), .ROW_W(ROW_W)) checks (
  .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
  .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .row_ctl_o(row_ctl_o), .product_signed_o(product_signed_o), .overflow_o(overflow_o),
  .to_left_o(to_left_o), .to_right_o(to_right_o), .route_o(route_o)
);

// [testbench/neighbour_clusters.sv]
// Purpose: Neighbour logic clusters driving the row direct connections
// Assumes: Lines change only on a load request, at a rising edge
// Notes: Row r left = {2'b10, seed ^ r}, right = {2'b01, seed + 8'h40 + r}
`timescale 1ns/100ps
module neighbour_clusters (
  // Clock and load request
  input wire clk_i,
  input wire load_i,
  input wire [7:0] seed_i,
  // Ten direct lines per row from each side
  output reg [79:0] from_left_o,
  output reg [79:0] from_right_o
);
  integer r;
  // Zero at start
  initial begin
    from_left_o = 80'h0;
    from_right_o = 80'h0;
  end
  // New pattern on request, held stable otherwise
  always @(posedge clk_i) begin
    if (load_i) begin
      for (r = 0; r < 8; r = r + 1) begin
        from_left_o[r*10+:10] <= {2'b10, seed_i ^ r[7:0]};
        from_right_o[r*10+:10] <= {2'b01, seed_i + 8'h40 + r[7:0]};
      end
    end
  end
endmodule // neighbour_clusters

// [testbench/tb.sv]
// Purpose: Self-checking bench for the row interface block
// Assumes: APB master and pin drivers act right after rising edges
// Notes: All banks bypassed except where a scenario registers a slot
`timescale 1ns/100ps
`include "dsp_row_consts.vh"
module tb;
  reg clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg psel_i = 1'b0;
  reg penable_i = 1'b0;
  reg pwrite_i = 1'b0;
  reg [7:0] paddr_i = 8'h00;
  reg [31:0] pwdata_i = 32'h0;
  reg [3:0] bank_clock_i = 4'h0;
  reg [3:0] bank_enable_i = 4'h0;
  reg [3:0] bank_clear_i = 4'h0;
  reg [5:0] ctl = 6'h00; // Control pins in slot order
  reg load = 1'b0;
  reg [7:0] seed = 8'h00;
  reg [31:0] q;
  reg e;
  reg [17:0] exp18;
  integer i, r;
  integer n_fail = 0;
  integer checks_done = 0;
  wire [79:0] from_left, from_right;
  wire [31:0] prdata_o;
  wire pready_o, pslverr_o, product_signed_o;
  wire [143:0] operand_o;
  wire [5:0] row_ctl_o;
  // Clock, 100 MHz
  always #5 clk_i = ~clk_i;
  neighbour_clusters nbr (.clk_i(clk_i), .load_i(load), .seed_i(seed),
    .from_left_o(from_left), .from_right_o(from_right));
  dsp_row_interface_control uut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .bank_clock_i(bank_clock_i), .bank_enable_i(bank_enable_i), .bank_clear_i(bank_clear_i),
    .sign_a_i(ctl[0]), .sign_b_i(ctl[1]), .upper_pair_add_sel_i(ctl[2]),
    .lower_pair_add_sel_i(ctl[3]), .upper_accumulator_zero_i(ctl[4]),
    .lower_accumulator_zero_i(ctl[5]), .from_left_i(from_left), .from_right_i(from_right),
    .operand_o(operand_o), .row_ctl_o(row_ctl_o), .product_signed_o(product_signed_o),
    .overflow_o(), .to_left_o(), .to_right_o(), .route_o());
  // Closing report
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  // Word compare
  task chk(input string name, input [31:0] exp, input [31:0] got);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("wrong value %s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  // One APB transfer, bounded wait for pready
  task apb(input w, input [7:0] a, input [31:0] d, output [31:0] rq, output re);
    integer n;
    begin
      @(posedge clk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      n = 0;
      // Request held until the rising edge that samples pready high
      @(posedge clk_i);
      while (pready_o !== 1'b1 && n < 20) begin
        n = n + 1;
        @(posedge clk_i);
      end
      if (n >= 20) begin
        n_fail = n_fail + 1;
        print_verdict;
      end
      rq = prdata_o;
      re = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
    end
  endtask
  // Bank clock pulse long enough to be seen
  task pulse(input integer k);
    begin
      bank_clock_i[k] <= 1'b1;
      repeat (3) @(posedge clk_i);
      bank_clock_i[k] <= 1'b0;
      repeat (7) @(posedge clk_i);
    end
  endtask
  // Main sequence
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    for (i = 0; i < 3; i = i + 1) begin
      apb(1'b0, {i[5:0], 2'b00}, 32'h0, q, e);
      chk("reset value", 32'h0, q);
      apb(1'b1, {i[5:0], 2'b00}, 32'hffffffff, q, e);
      apb(1'b0, {i[5:0], 2'b00}, 32'h0, q, e);
      chk("readback", i == 0 ? 32'h1ff : i == 1 ? 32'h3fffffff : 32'hfffff, q);
      apb(1'b1, {i[5:0], 2'b00}, 32'h0, q, e);
    end
    apb(1'b0, 8'h18, 32'h0, q, e);
    chk("unmapped error", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
    apb(1'b1, `OFS_STATUS, 32'hffffffff, q, e);
    // Bypassed operands from both neighbours
    for (i = 0; i < 2; i = i + 1) begin
      seed <= i == 0 ? 8'h35 : 8'hca;
      load <= 1'b1;
      @(posedge clk_i);
      load <= 1'b0;
      repeat (6) @(posedge clk_i);
      for (r = 0; r < 8; r = r + 1) begin
        exp18 = {1'b1, seed + 8'h40 + r[7:0], 1'b0, seed ^ r[7:0]};
        chk("operand row", {14'h0, exp18}, {14'h0, operand_o[r*18+:18]});
      end
    end
    // Four sign, add and zero patterns, covering every sign combination
    for (i = 0; i < 4; i = i + 1) begin
      ctl <= {i[1:0], ~i[1:0], i[1:0]};
      bank_enable_i <= {i[1:0], ~i[1:0]};
      repeat (6) @(posedge clk_i);
      chk("product signed", {31'h0, i[0] | i[1]}, {31'h0, product_signed_o});
      chk("row controls", {26'h0, ctl}, {26'h0, row_ctl_o});
      apb(1'b0, `OFS_STATUS, 32'h0, q, e);
      chk("status", {8'h0, ctl, ctl, bank_enable_i, 8'h00}, q & 32'h00ffffff);
    end
    // Slot 0 registered on clock 0, cleared by clear line 1
    apb(1'b1, `OFS_SLOT_CFG, 32'h9, q, e);
    ctl <= 6'h01;
    bank_enable_i <= 4'h1;
    repeat (6) @(posedge clk_i);
    chk("slot before clock", 32'h0, {31'h0, row_ctl_o[0]});
    pulse(0);
    chk("slot loaded", 32'h1, {31'h0, row_ctl_o[0]});
    ctl <= 6'h00;
    bank_enable_i <= 4'h0;
    pulse(0);
    chk("slot enable low", 32'h1, {31'h0, row_ctl_o[0]});
    chk("sign held", 32'h1, {31'h0, product_signed_o});
    bank_clear_i <= 4'h2;
    repeat (6) @(posedge clk_i);
    chk("slot cleared", 32'h0, {31'h0, row_ctl_o[0]});
    bank_clear_i <= 4'h0;
    // Upper pair: zero then add rows 0 and 1, then subtract them
    ctl <= 6'h14;
    bank_enable_i <= 4'h1;
    pulse(0);
    apb(1'b0, `OFS_ACC_UPPER, 32'h0, q, e);
    chk("acc zero and add", 32'h00042b95, q);
    ctl <= 6'h00;
    pulse(0);
    apb(1'b0, `OFS_ACC_UPPER, 32'h0, q, e);
    chk("acc subtract", 32'h00042994, q);
    print_verdict;
  end
endmodule // tb
